// File: include/disk_func_defines.vh
// Constants for the disk address and interrupt function block
// Notes on behaviour
// - Load-cylinder stores bits 0-9, then seeks absolutely
// - Cylinder, sector, head outputs and current sector need idle and selection
// - Cylinder status returns register; zero after return-to-zero
// - Cylinder status refused busy; tracks last data cylinder
// - Format-write writes zeroes index to next index
// - Format-write end clears busy, sets transfer complete
// - Format-write needs selection and not busy
// - Current sector returns sector under heads, from zero
// - Sector/head output loads fields, issues head-select
// - Address transfers start at index before sector zero
// - Sector/head status echoes write; zero after return-to-zero
// - Status bit 7 flags last logical sector
// - Sector/head status refused busy; shows last worked
// - Clear-interface bit ends seek and format, clears pending and mask, deselects; cylinder/sector/head registers kept
// - Clear-interrupts bit clears pending and whole mask
// - After clears, conditions still set status bits
// - Mask code in bits 2-4 picks condition
// - Bit 5 enables or locks out chosen condition
// - Seek-end raised for every seek issued
// - Selection interrupt when selection first gained
// - End-of-cylinder interrupt when transfer overruns cylinder
// - Director function accepted at any moment
`ifndef DISK_FUNC_DEFINES_VH
`define DISK_FUNC_DEFINES_VH

// Function codes
`define FC_CYLINDER     4'h5
`define FC_FMT_SECTOR   4'h6
`define FC_SECTOR_HEAD  4'h7
`define FC_DIRECTOR     4'h8

// Word fields
`define CYL_MSB         9
`define SEC_MSB         6
`define HEAD_LSB        8
`define HEAD_MSB        10
`define LAST_SEC_BIT    7
`define DIR_CLR_IF      0
`define DIR_CLR_INT     1
`define DIR_CODE_LSB    2
`define DIR_CODE_MSB    4
`define DIR_ENABLE      5

// Condition numbers, also mask-selection codes
`define COND_SELECTED   3'h1
`define COND_XFER_DONE  3'h2
`define COND_ALARM      3'h3
`define COND_SEEK_END   3'h4
`define COND_END_CYL    3'h5
`define COND_ALT_INT    3'h6

// Back-end command codes
`define CMD_SEEK        2'h1
`define CMD_HEAD_SEL    2'h2
`define CMD_FORMAT      2'h3

// Reset values
`define CYL_RESET       10'h000
`define SEC_RESET       7'h00
`define HEAD_RESET      3'h0
`define MASK_RESET      6'h00
`define WORD_ZERO       16'h0000

`endif

// File: core/pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             mclk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] pinIn,
    output reg  [WIDTH-1:0] pinOut
);
    reg  [WIDTH-1:0] stage1;
    reg  [WIDTH-1:0] stage2;
    reg  [WIDTH-1:0] stage3;
    wire [WIDTH-1:0] next_pinOut;
    genvar i;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            stage3 <= {WIDTH{1'b0}};
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit only moves once the last two stages agree
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_agree
            assign next_pinOut[i] = (stage2[i] == stage3[i]) ? stage3[i]
                                                             : pinOut[i];
        end
    endgenerate

    // One process owns the whole output, so it has a single driver
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinOut <= {WIDTH{1'b0}};
        end else begin
            pinOut <= next_pinOut;
        end
    end
endmodule // pin_sync

// File: core/disk_func_core.v
// Disk address, format and interrupt-mask function handling
`timescale 1ns/100ps
`include "disk_func_defines.vh"
module disk_func_core (
    input  wire        mclk,
    input  wire        rst_n,
    // Host function port
    input  wire        funcStrobe,
    input  wire        funcIsInput,
    input  wire [3:0]  funcCode,
    input  wire [15:0] aWord,
    output reg         funcAccept,
    output reg         funcReject,
    output reg  [15:0] inWord,
    output wire        hostIrq,
    output reg  [6:0]  statusBits,
    // Controller/formatter pins
    input  wire        selGrantPin,
    input  wire        ctlAckPin,
    input  wire        indexPin,
    input  wire [6:0]  sectorPin,
    output reg         ctlRelease,
    output reg         cmdValid,
    output reg  [1:0]  cmdOp,
    output reg  [9:0]  cmdCyl,
    output reg  [2:0]  cmdHead,
    output reg         writeZeroes,
    // Transfer engine, same clock
    input  wire        dmaBusy,
    input  wire        dmaUpdate,
    input  wire [9:0]  dmaCyl,
    input  wire [6:0]  dmaSector,
    input  wire [2:0]  dmaHead,
    input  wire        dmaLastSec,
    input  wire        dmaDone,
    input  wire        dmaEoc,
    input  wire        dmaAddrMode,
    output reg  [6:0]  startSector,
    input  wire        rtzSeek,
    input  wire        offsetSeek,
    input  wire        alarmEvent,
    input  wire        altIntEvent
);
    // Format-write states
    localparam [2:0] F_IDLE  = 3'b001;
    localparam [2:0] F_WAIT  = 3'b010;
    localparam [2:0] F_WRITE = 3'b100;

    //--------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------
    wire [9:0] pinsSync;
    wire       selGrant = pinsSync[0];
    wire       ctlAck   = pinsSync[1];
    wire       indexMk  = pinsSync[2];
    wire [6:0] curSector = pinsSync[9:3];

    pin_sync #(
        .WIDTH(10)
    ) u_pins (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .pinIn  ({sectorPin, indexPin, ctlAckPin, selGrantPin}),
        .pinOut (pinsSync)
    );

    reg  selGrantQ;
    reg  ctlAckQ;
    reg  indexQ;
    wire selRise   = selGrant & ~selGrantQ;
    wire ackRise   = ctlAck & ~ctlAckQ;
    wire indexRise = indexMk & ~indexQ;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            selGrantQ <= 1'b0;
            ctlAckQ   <= 1'b0;
            indexQ    <= 1'b0;
        end else begin
            selGrantQ <= selGrant;
            ctlAckQ   <= ctlAck;
            indexQ    <= indexMk;
        end
    end

    //--------------------------------------------------------
    // Function decode
    //--------------------------------------------------------
    function isCode;
        input [3:0] code;
        input [3:0] want;
        begin
            isCode = (code == want);
        end
    endfunction

    reg  [9:0] cylReg;
    reg  [6:0] secReg;
    reg  [2:0] headReg;
    reg        lastFlag;
    reg  [5:0] maskReg;
    reg  [5:0] pendReg;
    reg        selected;
    reg        seekBusy;
    reg  [2:0] fmtState;

    wire busy = seekBusy | dmaBusy | (fmtState != F_IDLE);
    wire idleSel = ~busy & selected;
    wire isOut = funcStrobe & ~funcIsInput;
    wire isIn  = funcStrobe & funcIsInput;

    wire doCyl  = isOut & isCode(funcCode, `FC_CYLINDER)
                  & idleSel;
    wire doFmt  = isOut & isCode(funcCode, `FC_FMT_SECTOR)
                  & idleSel;
    wire doSh   = isOut & isCode(funcCode, `FC_SECTOR_HEAD)
                  & idleSel;
    wire doDir  = isOut & isCode(funcCode, `FC_DIRECTOR);
    wire rdCyl  = isIn & isCode(funcCode, `FC_CYLINDER)
                  & ~busy;
    wire rdSec  = isIn & isCode(funcCode, `FC_FMT_SECTOR)
                  & idleSel;
    wire rdSh   = isIn & isCode(funcCode, `FC_SECTOR_HEAD)
                  & ~busy;

    wire clrIf  = doDir & aWord[`DIR_CLR_IF];
    wire clrInt = doDir & aWord[`DIR_CLR_INT];
    wire [2:0] dirCode = aWord[`DIR_CODE_MSB:`DIR_CODE_LSB];
    wire taken = doCyl | doFmt | doSh | doDir | rdCyl | rdSec | rdSh;

    //--------------------------------------------------------
    // Host answer
    //--------------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            funcAccept <= 1'b0;
            funcReject <= 1'b0;
            inWord     <= `WORD_ZERO;
        end else begin
            funcAccept <= taken;
            // Refusal only answers; no state moves
            funcReject <= funcStrobe & ~taken;
            if (rdCyl) begin
                inWord <= {6'h00, cylReg};
            end else if (rdSec) begin
                inWord <= {9'h000, curSector};
            end else if (rdSh) begin
                inWord <= {5'h00, headReg, lastFlag,
                           secReg};
            end
        end
    end

    //--------------------------------------------------------
    // Cylinder and sector/head registers
    //--------------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cylReg   <= `CYL_RESET;
            secReg   <= `SEC_RESET;
            headReg  <= `HEAD_RESET;
            lastFlag <= 1'b0;
        end else if (rtzSeek) begin
            cylReg   <= `CYL_RESET;
            secReg   <= `SEC_RESET;
            headReg  <= `HEAD_RESET;
            lastFlag <= 1'b0;
        end else if (dmaUpdate) begin
            // Last place actually worked on
            cylReg   <= dmaCyl;
            secReg   <= dmaSector;
            headReg  <= dmaHead;
            lastFlag <= dmaLastSec;
        end else begin
            if (doCyl) begin
                cylReg <= aWord[`CYL_MSB:0];
            end
            if (doSh) begin
                secReg   <= aWord[`SEC_MSB:0];
                headReg  <= aWord[`HEAD_MSB:`HEAD_LSB];
                lastFlag <= 1'b0;
            end
        end
    end

    // Address transfers ignore the stored sector
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            startSector <= `SEC_RESET;
        end else begin
            startSector <= dmaAddrMode ? `SEC_RESET
                                       : secReg;
        end
    end

    //--------------------------------------------------------
    // Back-end commands
    //--------------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmdValid <= 1'b0;
            cmdOp    <= 2'h0;
            cmdCyl   <= `CYL_RESET;
            cmdHead  <= `HEAD_RESET;
        end else begin
            cmdValid <= doCyl | doSh | doFmt;
            if (doCyl) begin
                cmdOp  <= `CMD_SEEK;
                cmdCyl <= aWord[`CYL_MSB:0];
            end else if (doSh) begin
                cmdOp   <= `CMD_HEAD_SEL;
                cmdHead <= aWord[`HEAD_MSB:`HEAD_LSB];
            end else if (doFmt) begin
                cmdOp <= `CMD_FORMAT;
            end
        end
    end

    // Seek holds busy until the formatter acknowledges
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seekBusy <= 1'b0;
        end else if (clrIf) begin
            seekBusy <= 1'b0;
        end else if (doCyl) begin
            seekBusy <= 1'b1;
        end else if (ackRise) begin
            seekBusy <= 1'b0;
        end
    end

    //--------------------------------------------------------
    // Format-write sequencer
    //--------------------------------------------------------
    reg [2:0] next_fmtState;
    reg       fmtEnd;

    always @* begin
        next_fmtState = fmtState;
        fmtEnd = 1'b0;
        case (fmtState)
            F_IDLE: begin
                if (doFmt) begin
                    next_fmtState = F_WAIT;
                end
            end
            F_WAIT: begin
                if (indexRise) begin
                    next_fmtState = F_WRITE;
                end
            end
            F_WRITE: begin
                if (indexRise) begin
                    next_fmtState = F_IDLE;
                    fmtEnd = 1'b1;
                end
            end
            default: begin
                next_fmtState = F_IDLE;
            end
        endcase
        if (clrIf) begin
            next_fmtState = F_IDLE;
            fmtEnd = 1'b0;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fmtState    <= F_IDLE;
            writeZeroes <= 1'b0;
        end else begin
            fmtState    <= next_fmtState;
            writeZeroes <= (next_fmtState == F_WRITE);
        end
    end

    //--------------------------------------------------------
    // Selection
    //--------------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            selected   <= 1'b0;
            ctlRelease <= 1'b0;
        end else begin
            ctlRelease <= clrIf;
            if (selRise) begin
                selected <= 1'b1;
            end else if (clrIf | ~selGrant) begin
                selected <= 1'b0;
            end
        end
    end

    //--------------------------------------------------------
    // Conditions, mask and interrupt
    //--------------------------------------------------------
    // Condition n sits at bit n-1
    function [5:0] condBit;
        input [2:0] code;
        begin
            case (code)
                `COND_SELECTED:  condBit = 6'h01;
                `COND_XFER_DONE: condBit = 6'h02;
                `COND_ALARM:     condBit = 6'h04;
                `COND_SEEK_END:  condBit = 6'h08;
                `COND_END_CYL:   condBit = 6'h10;
                `COND_ALT_INT:   condBit = 6'h20;
                default:         condBit = 6'h00;
            endcase
        end
    endfunction

    wire seekEv = doCyl | rtzSeek | offsetSeek;
    wire [5:0] condSet = condBit(`COND_SELECTED) & {6{selRise}}
                       | condBit(`COND_XFER_DONE)
                         & {6{fmtEnd | dmaDone}}
                       | condBit(`COND_ALARM) & {6{alarmEvent}}
                       | condBit(`COND_SEEK_END) & {6{seekEv}}
                       | condBit(`COND_END_CYL) & {6{dmaEoc}}
                       | condBit(`COND_ALT_INT)
                         & {6{altIntEvent}};
    wire [5:0] dirSel = condBit(dirCode);

    // A new event beats a clear in the same cycle
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pendReg <= `MASK_RESET;
        end else if (clrIf | clrInt) begin
            pendReg <= condSet;
        end else begin
            pendReg <= pendReg | condSet;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            maskReg <= `MASK_RESET;
        end else if (doDir) begin
            // Clears first, then the chosen enable applies
            if (aWord[`DIR_ENABLE]) begin
                maskReg <= ((clrIf | clrInt) ? `MASK_RESET
                                             : maskReg)
                           | dirSel;
            end else begin
                maskReg <= ((clrIf | clrInt) ? `MASK_RESET
                                             : maskReg)
                           & ~dirSel;
            end
        end
    end

    // Each enabled condition can interrupt
    assign hostIrq = |(pendReg & maskReg);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            statusBits <= 7'h00;
        end else begin
            statusBits <= {pendReg, busy};
        end
    end
endmodule // disk_func_core

// File: testbench/disk_func_checker.sv
// Concurrent checks on the disk function core ports
`timescale 1ns/100ps
module disk_func_checker (
    input logic        mclk,
    input logic        rst_n,
    input logic        funcStrobe,
    input logic        funcIsInput,
    input logic [3:0]  funcCode,
    input logic [15:0] aWord,
    input logic        funcAccept,
    input logic        funcReject,
    input logic        hostIrq,
    input logic [6:0]  statusBits,
    input logic        ctlRelease,
    input logic        cmdValid,
    input logic [1:0]  cmdOp,
    input logic [9:0]  cmdCyl,
    input logic [2:0]  cmdHead,
    input logic        writeZeroes,
    input logic        dmaAddrMode,
    input logic [6:0]  startSector
);
    // ----
    // Last request, kept so each answer can be tied to its cause
    // ----
    logic        pOut;
    logic [3:0]  pCode;
    logic [15:0] pA;
    wire         okOut;
    always @(posedge mclk) begin
        pOut  <= funcStrobe && !funcIsInput;
        pCode <= funcCode;
        pA    <= aWord;
    end
    assign okOut = funcAccept && pOut;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_seek_command: assert property (okOut && pCode == 4'h5 |->
        cmdValid && cmdOp == 2'h1 && cmdCyl == pA[9:0])
        else $error("seek command differs from loaded cylinder");
    a_seek_end_raised: assert property (okOut && pCode == 4'h5 |->
        ##[0:2] statusBits[4])
        else $error("seek end not raised after load cylinder");
    a_head_select: assert property (okOut && pCode == 4'h7 |->
        cmdValid && cmdOp == 2'h2 && cmdHead == pA[10:8])
        else $error("head select differs from written head");
    a_format_start: assert property (okOut && pCode == 4'h6 |->
        cmdValid && cmdOp == 2'h3)
        else $error("format command not issued");
    a_refuse_silent: assert property (funcReject |->
        !cmdValid && !ctlRelease)
        else $error("refused function reached the back end");
    a_zeroes_busy: assert property ($rose(writeZeroes) |->
        statusBits[0])
        else $error("zero writing while not busy");
    // A format cut short by clear-interface is not a finished track
    a_format_done: assert property ($fell(writeZeroes) &&
        !ctlRelease |-> ##[0:2] !statusBits[0] && statusBits[2])
        else $error("format end without idle and transfer complete");
    a_clear_quiet: assert property (okOut && pCode == 4'h8 &&
        pA[1:0] != 2'h0 && !pA[5] |-> !hostIrq)
        else $error("interrupt survives a clear");
    a_clear_release: assert property (okOut && pCode == 4'h8 &&
        pA[0] |-> ##[0:1] ctlRelease)
        else $error("clear interface did not deselect");
    a_director_taken: assert property (funcStrobe && funcCode == 4'h8 &&
        !funcIsInput |=> funcAccept)
        else $error("director function refused");
    a_addr_start: assert property (dmaAddrMode && $past(dmaAddrMode) |->
        startSector == 7'h00)
        else $error("address transfer not started at sector zero");
    cover property (okOut && pCode == 4'h5);
    cover property ($fell(writeZeroes));
    cover property (hostIrq);
    cover property (funcReject);
endmodule // disk_func_checker

bind disk_func_core disk_func_checker u_chk (
    .mclk(mclk), .rst_n(rst_n), .funcStrobe(funcStrobe),
    .funcIsInput(funcIsInput), .funcCode(funcCode), .aWord(aWord),
    .funcAccept(funcAccept), .funcReject(funcReject), .hostIrq(hostIrq),
    .statusBits(statusBits), .ctlRelease(ctlRelease),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdCyl(cmdCyl),
    .cmdHead(cmdHead), .writeZeroes(writeZeroes),
    .dmaAddrMode(dmaAddrMode), .startSector(startSector)
);

// File: testbench/disk_func_partner.sv
// Controller/formatter and rotating drive model
`timescale 1ns/100ps
module disk_func_partner #(
    parameter NSEC = 16,
    parameter SCYC = 20
) (
    input  logic       mclk,
    input  logic       rst_n,
    input  logic       selReq,
    input  logic       slowAck,
    input  logic       cmdValid,
    input  logic [1:0] cmdOp,
    input  logic       ctlRelease,
    output logic       selGrantPin,
    output logic       ctlAckPin,
    output logic       indexPin,
    output logic [6:0] sectorPin
);
    int ackCnt;
    int tick;
    // ----
    // Ack held 8 cycles so it survives the pin filter
    // ----
    assign ctlAckPin = ackCnt > 0 && ackCnt <= 8;
    assign indexPin  = tick < 6;
    assign sectorPin = 7'(tick / SCYC);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            selGrantPin <= 1'h0;
            ackCnt      <= 0;
            tick        <= 0;
        end else begin
            tick <= (tick == NSEC * SCYC - 1) ? 0 : tick + 1;
            if (ctlRelease)
                selGrantPin <= 1'h0;
            else if (selReq)
                selGrantPin <= 1'h1;
            if (cmdValid && cmdOp == 2'h1)
                ackCnt <= slowAck ? 68 : 13;
            else if (ackCnt > 0)
                ackCnt <= ackCnt - 1;
        end
    end
endmodule // disk_func_partner

// File: testbench/disk_address_and_interrupt_functions_tb_top.sv
// Self-checking bench for the disk function core
`timescale 1ns/100ps
module disk_address_and_interrupt_functions_tb_top;
    localparam NSEC = 16;
    localparam SCYC = 20;
    logic        mclk = 0;
    logic        rst_n = 0;
    logic        funcStrobe = 0;
    logic        funcIsInput = 0;
    logic [3:0]  funcCode = 4'h0;
    logic [15:0] aWord = 16'h0000;
    logic        dmaBusy = 0;
    logic        dmaUpdate = 0;
    logic [9:0]  dmaCyl = 10'h000;
    logic [6:0]  dmaSector = 7'h00;
    logic [2:0]  dmaHead = 3'h0;
    logic        dmaLastSec = 0;
    logic        dmaAddrMode = 0;
    logic        rtzSeek = 0;
    logic [4:0]  ev = 5'h00;
    logic        selReq = 0;
    logic        slowAck = 1;
    logic        ok;
    logic [15:0] rd;
    wire         funcAccept, funcReject, hostIrq, ctlRelease, cmdValid;
    wire         writeZeroes, selGrantPin, ctlAckPin, indexPin;
    wire  [15:0] inWord;
    wire  [6:0]  statusBits, startSector, sectorPin;
    wire  [1:0]  cmdOp;
    wire  [9:0]  cmdCyl;
    wire  [2:0]  cmdHead;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cyc = 0;

    disk_func_core DUT (
        .mclk, .rst_n, .funcStrobe, .funcIsInput, .funcCode, .aWord,
        .funcAccept, .funcReject, .inWord, .hostIrq, .statusBits,
        .selGrantPin, .ctlAckPin, .indexPin, .sectorPin, .ctlRelease,
        .cmdValid, .cmdOp, .cmdCyl, .cmdHead, .writeZeroes, .dmaBusy,
        .dmaUpdate, .dmaCyl, .dmaSector, .dmaHead, .dmaLastSec,
        .dmaDone(ev[0]), .dmaEoc(ev[4]), .dmaAddrMode, .startSector,
        .rtzSeek, .offsetSeek(ev[3]), .alarmEvent(ev[1]),
        .altIntEvent(ev[2])
    );
    disk_func_partner #(.NSEC(NSEC), .SCYC(SCYC)) PART (
        .mclk, .rst_n, .selReq, .slowAck, .cmdValid, .cmdOp,
        .ctlRelease, .selGrantPin, .ctlAckPin, .indexPin, .sectorPin
    );

    always #5 mclk = ~mclk;
    // Whole run needs about 1000 cycles; a hang stops far later
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ----
    // Shared tasks
    // ----
    task give_verdict;
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] s, e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task cy(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // One function; the answer stands only in the cycle after
    task fn(input logic i, input logic [3:0] c, input logic [15:0] a);
        funcStrobe = 1;
        funcIsInput = i;
        funcCode = c;
        aWord = a;
        cy(1);
        ok = funcAccept;
        rd = inWord;
        funcStrobe = 0;
        cy(1);
    endtask
    task idle;
        for (int k = 0; k < 300 && statusBits[0] !== 1'h0; k++)
            cy(1);
    endtask

    // ----
    // Scenarios
    // ----
    task t_refuse;
        for (int c = 5; c <= 7; c++) begin
            fn(0, c[3:0], 16'h0041);
            chk("unselected out", ok, 0);
        end
        fn(1, 4'h6, 0);
        chk("unselected sector", ok, 0);
        fn(1, 4'h5, 0);
        chk("cyl untouched", rd, 0);
        fn(1, 4'h7, 0);
        chk("sh untouched", rd, 0);
    endtask
    task t_select;
        fn(0, 4'h8, 16'h0024);
        selReq = 1;
        cy(1);
        selReq = 0;
        for (int k = 0; k < 20 && hostIrq !== 1'h1; k++)
            cy(1);
        chk("select irq", hostIrq, 1);
        fn(0, 4'h8, 16'h0002);
        chk("clear irq", hostIrq, 0);
        chk("clear pend", statusBits[6:1], 0);
    endtask
    task t_events;
        int cond[5] = '{2, 3, 6, 4, 5};
        for (int i = 0; i < 5; i++) begin
            ev[i] = 1;
            cy(1);
            ev[i] = 0;
            cy(3);
            chk("pending", statusBits[6:1], 6'h01 << (cond[i] - 1));
            chk("locked out", hostIrq, 0);
            fn(0, 4'h8, {10'h000, 1'h1, 3'(cond[i] % 6 + 1), 2'h0});
            chk("other code", hostIrq, 0);
            fn(0, 4'h8, {10'h000, 1'h1, 3'(cond[i]), 2'h0});
            chk("enabled", hostIrq, 1);
            fn(0, 4'h8, {10'h000, 1'h0, 3'(cond[i]), 2'h0});
            chk("disabled", hostIrq, 0);
            fn(0, 4'h8, 16'h0002);
        end
    endtask
    task t_seek;
        fn(0, 4'h5, 16'hA9C3);
        chk("seek cyl", cmdCyl, 16'h01C3);
        fn(1, 4'h5, 0);
        chk("busy cyl read", ok, 0);
        fn(1, 4'h7, 0);
        chk("busy sh read", ok, 0);
        fn(0, 4'h7, 16'h0102);
        chk("busy sh write", ok, 0);
        idle();
        fn(1, 4'h5, 0);
        chk("cyl read", rd, 16'h01C3);
        chk("seek end", statusBits[4], 1);
        fn(0, 4'h8, 16'h0002);
    endtask
    task t_sh;
        slowAck = 0;
        fn(0, 4'h7, 16'hF5D5);
        chk("head cmd", cmdHead, 16'h0005);
        fn(1, 4'h7, 0);
        chk("sh read", rd, 16'h0555);
        dmaAddrMode = 1;
        cy(2);
        chk("addr start", startSector, 0);
        dmaAddrMode = 0;
        cy(2);
        chk("data start", startSector, 16'h0055);
        dmaBusy = 1;
        dmaCyl = 10'h12A;
        dmaSector = 7'h3F;
        dmaHead = 3'h3;
        dmaLastSec = 1;
        dmaUpdate = 1;
        cy(1);
        dmaUpdate = 0;
        fn(1, 4'h7, 0);
        chk("dma busy sh", ok, 0);
        fn(0, 4'h8, 0);
        chk("dir while busy", ok, 1);
        dmaBusy = 0;
        cy(1);
        fn(1, 4'h5, 0);
        chk("last cyl", rd, 16'h012A);
        fn(1, 4'h7, 0);
        chk("last sh", rd, 16'h03BF);
        rtzSeek = 1;
        cy(1);
        rtzSeek = 0;
        idle();
        fn(1, 4'h5, 0);
        chk("rtz cyl", rd, 0);
        fn(1, 4'h7, 0);
        chk("rtz sh", rd, 0);
    endtask
    task t_sector;
        logic [6:0] s;
        wait (indexPin);
        cy(8);
        fn(1, 4'h6, 0);
        chk("index sector", rd, 0);
        s = sectorPin;
        wait (sectorPin != s);
        cy(8);
        fn(1, 4'h6, 0);
        chk("sector", rd, {9'h000, sectorPin});
    endtask
    task t_format;
        int n;
        fn(0, 4'h6, 0);
        chk("fmt taken", ok, 1);
        fn(0, 4'h6, 0);
        chk("fmt busy", ok, 0);
        for (n = 0; n < 400 && writeZeroes !== 1'h1; n++)
            cy(1);
        for (n = 0; n < 400 && writeZeroes === 1'h1; n++)
            cy(1);
        chk("fmt turn", n >= NSEC * SCYC - 1 && n <= NSEC * SCYC + 1, 1);
        cy(2);
        chk("fmt idle", statusBits[0], 0);
        chk("fmt done", statusBits[2], 1);
    endtask
    task t_clear_if;
        fn(0, 4'h6, 0);
        fn(0, 4'h8, 16'h0001);
        cy(2);
        chk("clear status", statusBits, 0);
        chk("clear zeroes", writeZeroes, 0);
        chk("deselected", selGrantPin, 0);
        fn(0, 4'h5, 16'h0010);
        chk("no selection", ok, 0);
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1;
        cy(1);
        t_refuse();
        t_select();
        t_events();
        t_seek();
        t_sh();
        t_sector();
        t_format();
        t_clear_if();
        give_verdict();
    end
endmodule // disk_address_and_interrupt_functions_tb_top
